// file: rtl/tpmc_cfg.svh
`ifndef TPMC_CFG_SVH
`define TPMC_CFG_SVH
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define TPMC_CLK_NS      10
`define TPMC_SEC_NS      1000000000
`define TPMC_SEC_W       27
`define TPMC_CNT_W       5
`define TPMC_IDENT_S     5'h12
`define TPMC_VFR_HOLD_S  5'h03
`define TPMC_SHOW_S      5'h05
`define TPMC_SHOW_MIN    5'h01
`define TPMC_SHOW_MAX    5'h04
`define TPMC_EDIT_MIN    5'h05
`define TPMC_EDIT_MAX    5'h13
// --------------------------------------------------------------
// reset values and codes
// --------------------------------------------------------------
`define TPMC_VFR_DEFAULT 12'hE00
`define TPMC_FID_BLANK   64'h2020202020202020
`define TPMC_AA_NONE     24'h000000
// --------------------------------------------------------------
// register byte offsets and fields
// --------------------------------------------------------------
`define TPMC_REG_CTRL    8'h00
`define TPMC_REG_AA      8'h04
`define TPMC_REG_CAT     8'h08
`define TPMC_REG_FIDL    8'h0C
`define TPMC_REG_FIDH    8'h10
`define TPMC_REG_SQWK    8'h14
`define TPMC_REG_STAT    8'h18
`define TPMC_REG_VFRC    8'h1C
`define TPMC_CTRL_GND    0
`endif

// file: rtl/tpmc_pkg.sv
package tpmc_pkg;
	// operating modes, one-hot
	typedef enum logic [4:0] {
		TPMC_STANDBY    = 5'h01,
		TPMC_FULL_REPLY = 5'h02,
		TPMC_NO_ALT     = 5'h04,
		TPMC_LEGACY_TWO = 5'h08,
		TPMC_IDENT_ONLY = 5'h10
	} tpmc_mode_t;
	// display screens, one-hot
	typedef enum logic [2:0] {
		TPMC_SCR_NORMAL = 3'h1,
		TPMC_SCR_SHOW   = 3'h2,
		TPMC_SCR_EDIT   = 3'h4
	} tpmc_screen_t;
endpackage : tpmc_pkg

// file: rtl/tpmc_sec_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "tpmc_cfg.svh"
// seconds counter: counts whole seconds while run is high, saturates
module tpmc_sec_timer #(
	parameter int unsigned SEC_CYC = `TPMC_SEC_NS / `TPMC_CLK_NS
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	// control
	input  wire logic                  clear,
	input  wire logic                  run,
	// count of elapsed seconds
	output var  logic [`TPMC_CNT_W-1:0] secs_q
);
	localparam logic [`TPMC_SEC_W-1:0] LAST = `TPMC_SEC_W'(SEC_CYC - 1);
	localparam logic [`TPMC_CNT_W-1:0] TOP  = '1;

	logic [`TPMC_SEC_W-1:0] cyc_q;
	wire                    wrap = (cyc_q == LAST);

	// clear wins over run so a restart always begins at zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q  <= '0;
			secs_q <= '0;
		end else if (clear) begin
			cyc_q  <= '0;
			secs_q <= '0;
		end else if (run) begin
			cyc_q <= wrap ? '0 : cyc_q + 1'b1;
			if (wrap && secs_q != TOP)
				secs_q <= secs_q + 1'b1; // saturate, never wrap back
		end
	end
endmodule : tpmc_sec_timer
`default_nettype wire

// file: rtl/tpmc_top.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tpmc_cfg.svh"
// Function
// RULE1: standby answers only addressed S, squitter on
// RULE2: mode button steps through selectable modes
// RULE3: full reply mode answers A, C, S
// RULE4: no-altitude mode drops altitude, keeps rest
// RULE5: zero address means no Mode S modes
// RULE6: legacy two-mode answers A and C
// RULE7: identity-only mode answers A only
// RULE8: swap exchanges active and standby codes
// RULE9: visual-flight code defaults to 7000
// RULE10: short visual press activates visual code
// RULE11: three second hold stores active code
// RULE12: mark press adds pulse for 18 s
// RULE13: standby release at 1..4 shows identifier
// RULE14: standby release at 5..19 opens editor
// RULE15: identifier screen closes after 5 s
// RULE16: screen layout address, category, identifier
// RULE17: mode press in editor saves, returns standby
// RULE18: enabled ground contact forces standby
// RULE19: external switch grounds input on ground
// RULE20: ground input ignored unless enabled
// RULE21: each party quenches other while transmitting
// RULE22: external quench withholds own transmissions
// RULE23: power-on starts in standby
// RULE24: hold counter counts seconds, cleared on release
module tpmc_top import tpmc_pkg::*; #(
	parameter int unsigned SEC_CYC = `TPMC_SEC_NS / `TPMC_CLK_NS
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst_n,
	// register port
	input  wire logic [7:0]   addr,
	input  wire logic [31:0]  wdata,
	input  wire logic         wr,
	input  wire logic         rd,
	output var  logic [31:0]  rdata_q,
	// front panel, levels
	input  wire logic         mode_btn,
	input  wire logic         swap_btn,
	input  wire logic         vfr_btn,
	input  wire logic         mark_request_button,
	input  wire logic         cursor_btn,
	input  wire logic         knob_up,
	input  wire logic         knob_dn,
	input  wire logic         ground_contact_input_n,
	// display
	output var  tpmc_mode_t   mode_q,
	output var  tpmc_screen_t screen_q,
	output var  logic [11:0]  active_q,
	output var  logic [11:0]  standby_q,
	output var  logic         vfr_ind_q,
	output var  logic         store_ind_q,
	output var  logic         ident_indicator_q,
	output var  logic [4:0]   hold_count_q,
	output var  logic [127:0] id_line_q,
	// interrogations, one-cycle pulses
	input  wire logic         intg_a,
	input  wire logic         intg_c,
	input  wire logic         intg_s,
	input  wire logic         intg_s_own,
	// reply permissions
	output var  logic         reply_a_q,
	output var  logic         reply_c_q,
	output var  logic         reply_s_q,
	output var  logic         reply_alt_q,
	output var  logic         reply_spi_q,
	output var  logic         squitter_en_q,
	// mutual quench line
	input  wire logic         own_tx_busy,
	input  wire logic         mutual_quench_line_i,
	output var  logic         mutual_quench_line_o_q,
	output var  logic         mutual_quench_line_oe_q
);
	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	function automatic logic [7:0] hex_asc(input logic [3:0] n);
		hex_asc = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
	endfunction : hex_asc

	function automatic tpmc_mode_t mode_next(input tpmc_mode_t m, input logic s);
		unique case (m)
			TPMC_STANDBY:    mode_next = s ? TPMC_FULL_REPLY : TPMC_LEGACY_TWO;
			TPMC_FULL_REPLY: mode_next = TPMC_NO_ALT;
			TPMC_LEGACY_TWO: mode_next = TPMC_IDENT_ONLY;
			default:         mode_next = TPMC_STANDBY;
		endcase
	endfunction : mode_next

	// ----------------------------------------------------------
	// registers and edges
	// ----------------------------------------------------------
	logic        gnd_en_q;
	logic [23:0] aa_q;
	logic [7:0]  cat_q;
	logic [63:0] fid_q, fid_work_q;
	logic [11:0] vfr_code_q;
	logic [2:0]  fid_cur_q;
	logic [1:0]  sq_cur_q;
	logic [4:0]  btn_prev_q;
	logic        stored_q;
	logic [4:0]  ident_secs, vfr_secs, show_secs;

	wire mode_pe  = mode_btn & ~btn_prev_q[0];
	wire swap_pe  = swap_btn & ~btn_prev_q[1];
	wire vfr_fe   = ~vfr_btn & btn_prev_q[2];
	wire mark_pe  = mark_request_button & ~btn_prev_q[3];
	wire mark_fe  = ~mark_request_button & btn_prev_q[3];
	wire cur_pe   = cursor_btn & ~btn_prev_q[4];
	wire has_s    = (aa_q != `TPMC_AA_NONE);                 // see RULE5
	wire gnd_frc  = gnd_en_q & ~ground_contact_input_n;      // see RULE18 see RULE20
	wire is_standby_state  = (mode_q == TPMC_STANDBY);
	wire normal   = (screen_q == TPMC_SCR_NORMAL);
	wire editing  = (screen_q == TPMC_SCR_EDIT);
	wire ext_q    = mutual_quench_line_i & ~mutual_quench_line_oe_q;
	wire vfr_hold = vfr_btn & ~stored_q & (vfr_secs == `TPMC_VFR_HOLD_S);
	wire ident_go = mark_pe & ~is_standby_state;
	wire rel_show = mark_fe & is_standby_state & normal & (hold_count_q >= `TPMC_SHOW_MIN)
	                & (hold_count_q <= `TPMC_SHOW_MAX);
	wire rel_edit = mark_fe & is_standby_state & normal & (hold_count_q >= `TPMC_EDIT_MIN)
	                & (hold_count_q <= `TPMC_EDIT_MAX);
	wire [1:0] knob = {knob_up, knob_dn};

	// button history for edge detection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			btn_prev_q <= '0;
		else
			btn_prev_q <= {cursor_btn, mark_request_button, vfr_btn, swap_btn, mode_btn};
	end

	// ----------------------------------------------------------
	// second timers
	// ----------------------------------------------------------
	tpmc_sec_timer #(.SEC_CYC(SEC_CYC)) u_ident (
		.clock  (clock),
		.rst_n  (rst_n),
		.clear  (ident_go | ~ident_indicator_q),
		.run    (ident_indicator_q),
		.secs_q (ident_secs)
	);
	tpmc_sec_timer #(.SEC_CYC(SEC_CYC)) u_hold (            // see RULE24
		.clock  (clock),
		.rst_n  (rst_n),
		.clear  (~mark_request_button),
		.run    (mark_request_button),
		.secs_q (hold_count_q)
	);
	tpmc_sec_timer #(.SEC_CYC(SEC_CYC)) u_vfr (
		.clock  (clock),
		.rst_n  (rst_n),
		.clear  (~vfr_btn),
		.run    (vfr_btn),
		.secs_q (vfr_secs)
	);
	tpmc_sec_timer #(.SEC_CYC(SEC_CYC)) u_show (
		.clock  (clock),
		.rst_n  (rst_n),
		.clear  (~(screen_q == TPMC_SCR_SHOW)),
		.run    (screen_q == TPMC_SCR_SHOW),
		.secs_q (show_secs)
	);

	// ----------------------------------------------------------
	// mode and screen
	// ----------------------------------------------------------
	// ground contact overrides the panel; it cannot be stepped away from
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			mode_q <= TPMC_STANDBY;                          // see RULE23
		else if (gnd_frc)
			mode_q <= TPMC_STANDBY;                          // see RULE18
		else if (editing && mode_pe)
			mode_q <= TPMC_STANDBY;                          // see RULE17
		else if (normal && mode_pe)
			mode_q <= mode_next(mode_q, has_s);              // see RULE2 see RULE5
		else if (!has_s && (mode_q == TPMC_FULL_REPLY || mode_q == TPMC_NO_ALT))
			mode_q <= TPMC_STANDBY;                          // address wiped by software
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			screen_q <= TPMC_SCR_NORMAL;
		else if (rel_show)
			screen_q <= TPMC_SCR_SHOW;                       // see RULE13
		else if (rel_edit)
			screen_q <= TPMC_SCR_EDIT;                       // see RULE14
		else if (screen_q == TPMC_SCR_SHOW && show_secs == `TPMC_SHOW_S)
			screen_q <= TPMC_SCR_NORMAL;                     // see RULE15
		else if (editing && mode_pe)
			screen_q <= TPMC_SCR_NORMAL;                     // see RULE17
	end

	// identifier line, character 1 leftmost in the top byte
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			id_line_q <= '0;
		else if (rel_show)
			id_line_q <= {hex_asc(aa_q[23:20]), hex_asc(aa_q[19:16]), hex_asc(aa_q[15:12]),
			              hex_asc(aa_q[11:8]), hex_asc(aa_q[7:4]), hex_asc(aa_q[3:0]),
			              hex_asc(cat_q[7:4]), hex_asc(cat_q[3:0]), fid_q}; // see RULE16
	end

	// ----------------------------------------------------------
	// ident pulse
	// ----------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			ident_indicator_q <= 1'b0;
		else if (ident_go)
			ident_indicator_q <= 1'b1;                       // see RULE12
		else if (ident_secs == `TPMC_IDENT_S)
			ident_indicator_q <= 1'b0;
	end

	// ----------------------------------------------------------
	// squawk codes
	// ----------------------------------------------------------
	// swap takes priority over a visual release in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			active_q    <= '0;
			standby_q   <= '0;
			vfr_code_q  <= `TPMC_VFR_DEFAULT;               // see RULE9
			vfr_ind_q   <= 1'b0;
			store_ind_q <= 1'b0;
			stored_q    <= 1'b0;
			sq_cur_q    <= '0;
		end else begin
			if (vfr_hold) begin
				vfr_code_q  <= active_q;                     // see RULE11
				stored_q    <= 1'b1;
				store_ind_q <= 1'b1;
			end
			if (swap_pe) begin
				active_q  <= standby_q;                      // see RULE8
				standby_q <= active_q;
				vfr_ind_q <= 1'b0;
			end else if (vfr_fe) begin
				stored_q    <= 1'b0;
				store_ind_q <= 1'b0;
				if (stored_q) begin
					vfr_ind_q <= 1'b1;                       // see RULE11
				end else if (vfr_ind_q) begin
					vfr_ind_q <= 1'b0;                       // see RULE10
				end else begin
					active_q  <= vfr_code_q;                 // see RULE10
					standby_q <= active_q;
					vfr_ind_q <= 1'b1;
				end
			end else if (normal && (knob != 2'b00 || cur_pe)) begin
				vfr_ind_q <= 1'b0;                           // standby code shown again
				if (cur_pe)
					sq_cur_q <= sq_cur_q + 1'b1;
				else if (knob_up)
					standby_q[sq_cur_q*3 +: 3] <= standby_q[sq_cur_q*3 +: 3] + 3'h1;
				else
					standby_q[sq_cur_q*3 +: 3] <= standby_q[sq_cur_q*3 +: 3] - 3'h1;
			end
		end
	end

	// ----------------------------------------------------------
	// flight identifier editor
	// ----------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fid_work_q <= `TPMC_FID_BLANK;
			fid_cur_q  <= '0;
		end else if (rel_edit) begin
			fid_work_q <= fid_q;                              // see RULE14
			fid_cur_q  <= '0;
		end else if (editing && cur_pe) begin
			fid_cur_q <= fid_cur_q + 1'b1;
		end else if (editing && knob_up) begin
			fid_work_q[(7 - fid_cur_q)*8 +: 8] <= fid_work_q[(7 - fid_cur_q)*8 +: 8] + 8'h01;
		end else if (editing && knob_dn) begin
			fid_work_q[(7 - fid_cur_q)*8 +: 8] <= fid_work_q[(7 - fid_cur_q)*8 +: 8] - 8'h01;
		end
	end

	// ----------------------------------------------------------
	// register port
	// ----------------------------------------------------------
	wire w_ctrl = wr && addr == `TPMC_REG_CTRL;
	wire w_aa   = wr && addr == `TPMC_REG_AA;
	wire w_cat  = wr && addr == `TPMC_REG_CAT;
	wire w_fidl = wr && addr == `TPMC_REG_FIDL;
	wire w_fidh = wr && addr == `TPMC_REG_FIDH;

	// editor save wins over a software write in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gnd_en_q <= 1'b0;
			aa_q     <= `TPMC_AA_NONE;
			cat_q    <= '0;
			fid_q    <= `TPMC_FID_BLANK;
		end else begin
			if (w_ctrl)
				gnd_en_q <= wdata[`TPMC_CTRL_GND];            // see RULE20
			if (w_aa)
				aa_q <= wdata[23:0];
			if (w_cat)
				cat_q <= wdata[7:0];
			if (editing && mode_pe)
				fid_q <= fid_work_q;                         // see RULE17
			else if (w_fidl)
				fid_q[31:0] <= wdata;
			else if (w_fidh)
				fid_q[63:32] <= wdata;
		end
	end

	logic [31:0] rd_mux;
	always_comb begin
		unique case (addr)
			`TPMC_REG_CTRL: rd_mux = {31'h0, gnd_en_q};
			`TPMC_REG_AA:   rd_mux = {8'h00, aa_q};
			`TPMC_REG_CAT:  rd_mux = {24'h0, cat_q};
			`TPMC_REG_FIDL: rd_mux = fid_q[31:0];
			`TPMC_REG_FIDH: rd_mux = fid_q[63:32];
			`TPMC_REG_SQWK: rd_mux = {4'h0, standby_q, 4'h0, active_q};
			`TPMC_REG_STAT: rd_mux = {11'h0, hold_count_q, 3'h0, ~ground_contact_input_n,
			                          ident_indicator_q, store_ind_q, vfr_ind_q, has_s,
			                          screen_q, mode_q};
			`TPMC_REG_VFRC: rd_mux = {20'h0, vfr_code_q};
			default:        rd_mux = '0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= '0;
		else
			rdata_q <= rd ? rd_mux : '0;
	end

	// ----------------------------------------------------------
	// reply permissions
	// ----------------------------------------------------------
	wire m_full = (mode_q == TPMC_FULL_REPLY);
	wire m_noal = (mode_q == TPMC_NO_ALT);
	wire m_leg  = (mode_q == TPMC_LEGACY_TWO);
	wire m_ida  = (mode_q == TPMC_IDENT_ONLY);
	wire ra_d   = ~ext_q & intg_a & (m_full | m_noal | m_leg | m_ida); // see RULE3 see RULE7
	wire rc_d   = ~ext_q & intg_c & (m_full | m_leg);                  // see RULE6
	wire rs_d   = ~ext_q & has_s & intg_s
	              & (m_full | m_noal | (is_standby_state & intg_s_own));         // see RULE1
	wire any_d  = ra_d | rc_d | rs_d;

	// an external quench blanks every reply and the squitter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reply_a_q     <= 1'b0;
			reply_c_q     <= 1'b0;
			reply_s_q     <= 1'b0;
			reply_alt_q   <= 1'b0;
			reply_spi_q   <= 1'b0;
			squitter_en_q <= 1'b0;
		end else begin
			reply_a_q     <= ra_d;                            // see RULE22
			reply_c_q     <= rc_d;
			reply_s_q     <= rs_d;
			reply_alt_q   <= (rc_d | rs_d) & ~m_noal;         // see RULE4
			reply_spi_q   <= any_d & ident_indicator_q;       // see RULE12
			squitter_en_q <= has_s & ~ext_q;                  // see RULE1
		end
	end

	// drive the shared line for the length of our own pulse train
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mutual_quench_line_o_q  <= 1'b0;
			mutual_quench_line_oe_q <= 1'b0;
		end else begin
			mutual_quench_line_o_q  <= 1'b1;
			mutual_quench_line_oe_q <= own_tx_busy;           // see RULE21
		end
	end

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	standby_no_a_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE1
		(is_standby_state && intg_a) |=> !reply_a_q) else $error("standby answered mode A");
	mode_step_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE2
		(normal && mode_pe && !gnd_frc && is_standby_state && has_s) |=> mode_q == TPMC_FULL_REPLY)
		else $error("mode did not step to full reply");
	full_reply_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE3
		(m_full && intg_a && !ext_q) |=> reply_a_q) else $error("full reply missed mode A");
	no_alt_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE4
		m_noal |=> !reply_alt_q) else $error("altitude sent in no-altitude mode");
	no_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE5
		!has_s |=> !reply_s_q && !squitter_en_q) else $error("mode S without address");
	swap_codes_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE8
		swap_pe |=> active_q == $past(standby_q) && standby_q == $past(active_q))
		else $error("swap did not exchange codes");
	ground_force_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE18
		gnd_frc |=> is_standby_state) else $error("ground contact did not force standby");
	quench_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE22
		ext_q |=> !(reply_a_q || reply_c_q || reply_s_q)) else $error("reply under quench");
	edit_save_a: assert property (@(posedge clock) disable iff (!rst_n) // see RULE17
		(editing && mode_pe) |=> fid_q == $past(fid_work_q) && normal && is_standby_state)
		else $error("editor save failed");
endmodule : tpmc_top
`default_nettype wire

// file: sim/tpmc_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// far side: radar interrogator, other transmitter, ground switch
module tpmc_far_model (
	// clock
	input  wire logic       clock,
	// requests from the bench
	input  wire logic [2:0] go,
	input  wire logic       own,
	input  wire logic       tx_on,
	input  wire logic       on_ground,
	// toward the device
	output var  logic       intg_a,
	output var  logic       intg_c,
	output var  logic       intg_s,
	output var  logic       intg_s_own,
	output var  logic       quench_drv,
	output wire logic       gnd_n
);
	// pulses are registered, so each lasts exactly as long as the bench holds its request
	always_ff @(posedge clock) begin
		{intg_a, intg_c, intg_s} <= go;
		intg_s_own <= own;
		quench_drv <= tx_on;
	end
	// the switch grounds the input on the ground, open (pulled high) in flight
	assign gnd_n = ~on_ground;
endmodule : tpmc_far_model
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top import tpmc_pkg::*;;
	localparam int SC = 10;
	logic clock, rst_n, wr, rd, own, tx_on, on_ground, busy, sti;
	logic [6:0] bt;
	logic [4:0] hold;
	logic [127:0] idl;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0] go;
	logic [23:0] aa;
	tpmc_mode_t mode;
	tpmc_screen_t scr;
	logic [11:0] act, stb;
	logic vfr_ind, ident_indicator, ra, rc, rs, ralt, rspi, sq, qo, qoe;
	logic i_a, i_c, i_s, i_own, qd;
	wire logic gnd_n;
	wire logic quench = qd | (qo & qoe);
	int err_total, n_compared, seed;
	typedef struct {logic [1:0] k; logic [33:0] v;} tpmc_exp_t;
	tpmc_exp_t exp_q[$];
	tpmc_exp_t e;
	event fire;

	tpmc_top #(.SEC_CYC(SC)) dut_u (.clock(clock), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata), .mode_btn(bt[0]),
		.swap_btn(bt[1]), .vfr_btn(bt[2]), .mark_request_button(bt[3]),
		.cursor_btn(bt[4]), .knob_up(bt[5]), .knob_dn(bt[6]),
		.ground_contact_input_n(gnd_n), .mode_q(mode), .screen_q(scr),
		.active_q(act), .standby_q(stb), .vfr_ind_q(vfr_ind), .store_ind_q(sti),
		.ident_indicator_q(ident_indicator), .hold_count_q(hold), .id_line_q(idl), .intg_a(i_a),
		.intg_c(i_c), .intg_s(i_s), .intg_s_own(i_own), .reply_a_q(ra),
		.reply_c_q(rc), .reply_s_q(rs), .reply_alt_q(ralt), .reply_spi_q(rspi),
		.squitter_en_q(sq), .own_tx_busy(busy), .mutual_quench_line_i(quench),
		.mutual_quench_line_o_q(qo), .mutual_quench_line_oe_q(qoe));
	tpmc_far_model far_u (.clock(clock), .go(go), .own(own), .tx_on(tx_on),
		.on_ground(on_ground), .intg_a(i_a), .intg_c(i_c), .intg_s(i_s),
		.intg_s_own(i_own), .quench_drv(qd), .gnd_n(gnd_n));

	// ----------------------------------------------------------
	// checking
	// ----------------------------------------------------------
	function automatic int xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(logic [33:0] g, logic [33:0] x);
		n_compared++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic cmp_rd(logic [31:0] x);
		chk({2'h0, rdata}, {2'h0, x});
	endtask : cmp_rd
	task automatic cmp_rep(logic [5:0] x);
		chk({28'h0, ra, rc, rs, rs & ralt, sq, rspi}, {28'h0, x});
	endtask : cmp_rep
	task automatic cmp_st(logic [33:0] x);
		chk({mode, scr, act, stb, vfr_ind, ident_indicator}, x);
	endtask : cmp_st
	// store flag, hold count, quench drive and characters 1, 8 and 9 of the line
	task automatic cmp_aux(logic [33:0] x);
		chk({sti, hold, qo, qoe, idl[127:120], idl[71:64], idl[63:56], 2'h0}, x);
	endtask : cmp_aux
	// oldest note is judged when the driver says its result is showing
	always @(fire) begin
		e = exp_q.pop_front();
		case (e.k)
			2'h0: cmp_rd(e.v[31:0]);
			2'h1: cmp_rep(e.v[5:0]);
			2'h2: cmp_st(e.v);
			default: cmp_aux(e.v);
		endcase
	end
	task automatic end_sim();
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------
	// drivers
	// ----------------------------------------------------------
	task automatic note(logic [1:0] k, logic [33:0] v);
		exp_q.push_back('{k, v});
		@(negedge clock) ->fire;
	endtask : note
	task automatic wreg(logic [7:0] a, logic [31:0] d);
		@(posedge clock) {wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clock) wr <= 1'b0;
	endtask : wreg
	task automatic rreg(logic [7:0] a, logic [31:0] x);
		@(posedge clock) {rd, addr} <= {1'b1, a};
		@(posedge clock) rd <= 1'b0;
		note(2'h0, {2'h0, x});
	endtask : rreg
	task automatic btn(int i, int n);
		@(posedge clock) bt[i] <= 1'b1;
		repeat (n) @(posedge clock);
		bt[i] <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : btn
	task automatic ask(logic [2:0] k, logic o, logic [5:0] x);
		@(posedge clock) {go, own} <= {k, o};
		@(posedge clock) {go, own} <= 4'h0;
		@(posedge clock);
		note(2'h1, {28'h0, x});
	endtask : ask
	task automatic st(tpmc_mode_t m, tpmc_screen_t s, logic [11:0] a, logic [11:0] b,
		logic v, logic i);
		note(2'h2, {m, s, a, b, v, i});
	endtask : st
	task automatic aux(logic s, logic [4:0] h, logic oe, logic [23:0] c);
		note(2'h3, {s, h, 1'b1, oe, c, 2'h0});
	endtask : aux

	// clock, watchdog and main sequence
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		repeat (4000) @(posedge clock);
		err_total++;
		end_sim();
	end
	initial begin
		{rst_n, wr, rd, own, tx_on, on_ground, busy, bt, addr, wdata, go} = '0;
		seed = 60;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'h000, 12'h000, 0, 0);
		aux(1'b0, 5'h00, 1'b0, 24'h000000);
		// hold the mark button past two seconds and look at the counter first
		@(posedge clock) bt[3] <= 1'b1;
		repeat (2 * SC + 5) @(posedge clock);
		aux(1'b0, 5'h02, 1'b0, 24'h000000);
		@(posedge clock) bt[3] <= 1'b0;
		repeat (3) @(posedge clock);
		st(TPMC_STANDBY, TPMC_SCR_SHOW, 12'h000, 12'h000, 0, 0);
		aux(1'b0, 5'h00, 1'b0, 24'h303020);
		repeat (4 * SC) @(posedge clock);
		st(TPMC_STANDBY, TPMC_SCR_SHOW, 12'h000, 12'h000, 0, 0);
		repeat (SC + 5) @(posedge clock);
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'h000, 12'h000, 0, 0);
		btn(3, 6 * SC + 5);
		st(TPMC_STANDBY, TPMC_SCR_EDIT, 12'h000, 12'h000, 0, 0);
		btn(4, 1);
		btn(5, 1);
		btn(0, 2);
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'h000, 12'h000, 0, 0);
		rreg(8'h10, 32'h20212020);
		btn(0, 2);
		ask(3'h4, 1, 6'h20);
		ask(3'h2, 1, 6'h10);
		ask(3'h1, 1, 6'h00);
		btn(0, 2);
		ask(3'h4, 1, 6'h20);
		ask(3'h2, 1, 6'h00);
		btn(0, 2);
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'h000, 12'h000, 0, 0);
		aa = 24'(xs()) | 24'h000001;
		wreg(8'h04, {8'h00, aa});
		rreg(8'h04, {8'h00, aa});
		rreg(8'h40, 32'h0);
		rreg(8'h1C, 32'h00000E00);
		ask(3'h4, 1, 6'h02);
		ask(3'h1, 0, 6'h02);
		ask(3'h1, 1, 6'h0E);
		btn(0, 2);
		ask(3'h4, 1, 6'h22);
		ask(3'h2, 1, 6'h12);
		ask(3'h1, 1, 6'h0E);
		@(posedge clock) tx_on <= 1'b1;
		ask(3'h4, 1, 6'h00);
		// our own drive of the shared line must not silence us
		@(posedge clock) {tx_on, busy} <= 2'b01;
		ask(3'h4, 1, 6'h22);
		aux(1'b0, 5'h00, 1'b1, 24'h303020);
		@(posedge clock) busy <= 1'b0;
		btn(0, 2);
		ask(3'h4, 1, 6'h22);
		ask(3'h2, 1, 6'h02);
		ask(3'h1, 1, 6'h0A);
		btn(0, 2);
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'h000, 12'h000, 0, 0);
		btn(2, 3);
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'hE00, 12'h000, 1, 0);
		btn(1, 2);
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'h000, 12'hE00, 0, 0);
		// long visual press stores the active code, indication shown while held
		@(posedge clock) bt[2] <= 1'b1;
		repeat (3 * SC + 2) @(posedge clock);
		aux(1'b1, 5'h00, 1'b0, 24'h303020);
		@(posedge clock) bt[2] <= 1'b0;
		repeat (3) @(posedge clock);
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'h000, 12'hE00, 1, 0);
		rreg(8'h1C, 32'h0);
		btn(2, 3);
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'h000, 12'hE00, 0, 0);
		@(posedge clock) on_ground <= 1'b1;
		btn(0, 2);
		st(TPMC_FULL_REPLY, TPMC_SCR_NORMAL, 12'h000, 12'hE00, 0, 0);
		wreg(8'h00, 32'h1);
		repeat (2) @(posedge clock);
		st(TPMC_STANDBY, TPMC_SCR_NORMAL, 12'h000, 12'hE00, 0, 0);
		@(posedge clock) on_ground <= 1'b0;
		btn(0, 2);
		btn(3, 2);
		ask(3'h4, 1, 6'h23);
		repeat (18 * SC - 15) @(posedge clock);
		st(TPMC_FULL_REPLY, TPMC_SCR_NORMAL, 12'h000, 12'hE00, 0, 1);
		repeat (20) @(posedge clock);
		st(TPMC_FULL_REPLY, TPMC_SCR_NORMAL, 12'h000, 12'hE00, 0, 0);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
